// ---- logic/chopper_defines.svh ----
// Purpose: Named constants for the chopper current control block
// Assumes: clk at 250 MHz, chopping oscillator arrives as a pin level
// Notes:   Times in ns, cycle counts derived from the clock period
`ifndef CHOPPER_DEFINES_SVH
`define CHOPPER_DEFINES_SVH

`define CLK_PERIOD_NS        4
// Fixed analog-style blank after switching in stepping mode
`define ANALOG_BLANK_NS      550
`define ANALOG_BLANK_CYC     ((`ANALOG_BLANK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Chopping period in oscillator periods
`define CHOP_PERIOD_OSC      16
// Charge held at DC start (25 % of the 16-period chopping period)
`define DC_START_CHARGE_OSC  4
// Fast decay share: 37.5 % of 16 periods
`define FAST_DECAY_OSC       6
// Over-current dead band and latest shutdown, in oscillator periods
`define OC_DEAD_BAND_OSC     4
`define OC_LATEST_OSC        8
// Dead time between phase changes in clk cycles
`define GATE_DEAD_CYC        2
// Digital blank codes from the mode-select setting
`define BLANK_SEL_2OSC       2'h0
`define BLANK_SEL_4OSC       2'h1
`define BLANK_SEL_6OSC       2'h2
`define BLANK_SEL_8OSC       2'h3

`endif

// ---- logic/chopper_pkg.sv ----
// Purpose: Types shared by the chopper current control files
// Assumes: nothing
// Notes:   Phase codes drive the gate map
package chopper_pkg;
  typedef enum logic [1:0] {
    PH_CHARGE = 2'b00,
    PH_SLOW   = 2'b01,
    PH_FAST   = 2'b10,
    PH_OFF    = 2'b11
  } phase_t;
endpackage

// ---- logic/pin_sync.sv ----
// Purpose: Two-flop synchroniser for one pin level
// Assumes: asynchronous input
// Notes:   First stage is read only by the second
`timescale 1ns/10ps
module pin_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  // Pin level in and synchronised level out
  input  wire logic din,
  output logic      dout
);
  logic meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      dout   <= 1'b0;
    end else if (ce) begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

// ---- logic/osc_counter.sv ----
// Purpose: Counter of chopping oscillator periods with terminal flag
// Assumes: tick is a one-cycle pulse per oscillator period
// Notes:   Restart loads zero; done holds once the count reaches limit
`timescale 1ns/10ps
module osc_counter #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  // Control
  input  wire logic             restart,
  input  wire logic             tick,
  input  wire logic [WIDTH-1:0] limit,
  // Status
  output logic                  done,
  output logic      [WIDTH-1:0] count
);
  initial begin
    if (WIDTH < 2) $error("osc_counter WIDTH too small");
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (ce) begin
      if (restart) begin
        count <= '0;
      end else if (tick && count != limit) begin
        count <= count + 1'b1;
      end
    end
  end

  assign done = (count == limit);
endmodule

// ---- logic/chopper_current_control.sv ----
// Purpose: PWM chopper sequencer for one H-bridge with over-current latch
// Assumes: oscillator, comparator and DC inputs are pins (synchronised)
// Notes:   Gates are active high; all gates low while shut down or idle
`timescale 1ns/10ps
`include "chopper_defines.svh"

// Notes on behaviour
// RL1 - Forward gate map for three phases
// RL2 - Reverse gate map for three phases
// RL3 - Phases chosen autonomously for constant current
// RL4 - Charge, then slow, then fast, repeat
// RL5 - Timing counted from oscillator clock ticks
// RL6 - Ignore over-current for four-period dead band
// RL7 - Shutdown four to eight periods after onset
// RL8 - DC mode digital blank masks detection
// RL9 - Blank length from initial mode select
// RL10 - Stepping mode: no digital blank
// RL11 - Stepping mode: fixed 550 ns blank
// RL12 - Shutdown holds until reset or standby
// RL13 - DC start: hold charge four periods
// RL14 - DC blank after PWM/direction edge, charge
// RL15 - Chopping period is sixteen oscillator periods
// RL16 - No shoot-through during phase changes
module chopper_current_control (
  // Clock, enable, reset
  input  wire logic clk,
  input  wire logic ce,
  input  wire logic rst_n,
  // Mode and control pins
  input  wire logic standby,
  input  wire logic dc_mode,
  input  wire logic [1:0] blank_sel,
  input  wire logic direction,
  input  wire logic pwm_in,
  // Oscillator and sense comparators
  input  wire logic chop_oscillator_clock,
  input  wire logic current_limit_reached,
  input  wire logic overcurrent_in,
  // Bridge gates and status
  output logic      high_side_gate_a,
  output logic      high_side_gate_b,
  output logic      low_side_gate_a,
  output logic      low_side_gate_b,
  output logic      overcurrent_shutdown,
  output chopper_pkg::phase_t phase_q
);
  import chopper_pkg::*;

  logic       osc_s, lim_s, oc_s, dir_s, pwm_s, stby_s, dc_s;
  logic       osc_prev_q, tick;
  logic       dir_prev_q, pwm_prev_q, in_edge;
  logic [3:0] per_q;
  logic       per_end;
  logic [1:0] blank_sel_q;
  logic       sel_taken_q;
  logic [3:0] dblank_lim;
  logic       dblank_restart, dblank_done;
  logic [3:0] dblank_cnt;
  logic [9:0] ablank_q;
  logic       blank_act;
  logic       oc_restart, oc_done;
  logic [3:0] oc_cnt;
  logic       start_q;
  logic       limit_hit_q;
  phase_t     phase_d;
  phase_t     gate_ph_q;
  logic [1:0] dead_q;
  logic       run;

  // Synchronise pin inputs
  pin_sync u_s_osc (.clk(clk), .rst_n(rst_n), .ce(ce),
                    .din(chop_oscillator_clock), .dout(osc_s));
  pin_sync u_s_lim (.clk(clk), .rst_n(rst_n), .ce(ce),
                    .din(current_limit_reached), .dout(lim_s));
  pin_sync u_s_oc  (.clk(clk), .rst_n(rst_n), .ce(ce),
                    .din(overcurrent_in), .dout(oc_s));
  pin_sync u_s_dir (.clk(clk), .rst_n(rst_n), .ce(ce),
                    .din(direction), .dout(dir_s));
  pin_sync u_s_pwm (.clk(clk), .rst_n(rst_n), .ce(ce),
                    .din(pwm_in), .dout(pwm_s));
  pin_sync u_s_stb (.clk(clk), .rst_n(rst_n), .ce(ce),
                    .din(standby), .dout(stby_s));
  pin_sync u_s_dc  (.clk(clk), .rst_n(rst_n), .ce(ce),
                    .din(dc_mode), .dout(dc_s));

  // RL5 oscillator tick edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_prev_q <= 1'b0;
      dir_prev_q <= 1'b0;
      pwm_prev_q <= 1'b0;
    end else if (ce) begin
      osc_prev_q <= osc_s;
      dir_prev_q <= dir_s;
      pwm_prev_q <= pwm_s;
    end
  end
  assign tick    = osc_s & ~osc_prev_q;
  assign in_edge = (dir_s ^ dir_prev_q) | (pwm_s ^ pwm_prev_q);
  assign run     = ~stby_s & ~overcurrent_shutdown & (~dc_s | pwm_s);

  // RL15 sixteen-period chopping frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      per_q <= 4'h0;
    end else if (ce) begin
      if (!run) begin
        per_q <= 4'h0;
      end else if (tick) begin
        per_q <= per_q + 4'h1;
      end
    end
  end
  assign per_end = tick &&
                   (per_q == 4'(`CHOP_PERIOD_OSC - 1));

  // RL9 blank length caught once after reset release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blank_sel_q <= `BLANK_SEL_4OSC;
      sel_taken_q <= 1'b0;
    end else if (ce && !sel_taken_q) begin
      blank_sel_q <= blank_sel;
      sel_taken_q <= 1'b1;
    end
  end

  always_comb begin
    unique case (blank_sel_q)
      `BLANK_SEL_2OSC: dblank_lim = 4'h2;
      `BLANK_SEL_4OSC: dblank_lim = 4'h4;
      `BLANK_SEL_6OSC: dblank_lim = 4'h6;
      `BLANK_SEL_8OSC: dblank_lim = 4'h8;
    endcase
  end

  // RL14 digital blank restarts on edges and charge start
  assign dblank_restart = in_edge ||
                          (phase_q != PH_CHARGE && phase_d == PH_CHARGE);

  // RL8 digital blank counter in oscillator periods
  osc_counter #(.WIDTH(4)) u_dblank (
    .clk(clk), .rst_n(rst_n), .ce(ce),
    .restart(dblank_restart), .tick(tick), .limit(dblank_lim),
    .done(dblank_done), .count(dblank_cnt));

  // RL11 fixed blank after every phase change
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ablank_q <= 10'h000;
    end else if (ce) begin
      if (phase_d != phase_q) begin
        ablank_q <= 10'(`ANALOG_BLANK_CYC);
      end else if (ablank_q != 10'h000) begin
        ablank_q <= ablank_q - 10'h001;
      end
    end
  end

  // RL10 digital blank only masks in DC mode
  assign blank_act = (ablank_q != 10'h000) || (dc_s && !dblank_done);

  // RL13 each DC frame opens with four charge periods
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_q <= 1'b1;
    end else if (ce) begin
      if (!run || per_end) begin
        start_q <= 1'b1;
      end else if (tick &&
                   per_q == 4'(`DC_START_CHARGE_OSC - 1)) begin
        start_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      limit_hit_q <= 1'b0;
    end else if (ce) begin
      limit_hit_q <= lim_s && !blank_act && phase_q == PH_CHARGE;
    end
  end

  // RL3 autonomous phase choice
  // RL4 charge, slow, fast, charge
  always_comb begin
    phase_d = phase_q;
    if (!run) begin
      phase_d = PH_OFF;
    end else begin
      unique case (phase_q)
        PH_OFF: phase_d = PH_CHARGE;
        PH_CHARGE: begin
          if (limit_hit_q && !(dc_s && start_q)) begin
            phase_d = PH_SLOW;
          end
          if (tick && per_q == 4'(`CHOP_PERIOD_OSC
                                  - `FAST_DECAY_OSC - 1)
              && limit_hit_q) begin
            phase_d = PH_FAST;
          end
        end
        PH_SLOW: begin
          if (tick && per_q == 4'(`CHOP_PERIOD_OSC
                                  - `FAST_DECAY_OSC - 1)) begin
            phase_d = PH_FAST;
          end
        end
        PH_FAST: begin
          if (per_end) begin
            phase_d = PH_CHARGE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= PH_OFF;
    end else if (ce) begin
      phase_q <= phase_d;
    end
  end

  // RL6 dead band and RL7 shutdown timer
  // RL8 only the digital blank masks over-current, so the fixed
  // blank after each phase change cannot stretch past eight periods
  assign oc_restart = !oc_s || (dc_s && !dblank_done);
  osc_counter #(.WIDTH(4)) u_oc (
    .clk(clk), .rst_n(rst_n), .ce(ce),
    .restart(oc_restart), .tick(tick),
    .limit(4'(`OC_DEAD_BAND_OSC)),
    .done(oc_done), .count(oc_cnt));

  // RL12 latched shutdown, cleared by standby or reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overcurrent_shutdown <= 1'b0;
    end else if (ce) begin
      if (stby_s) begin
        overcurrent_shutdown <= 1'b0;
      end else if (oc_done && tick) begin
        overcurrent_shutdown <= 1'b1;
      end
    end
  end

  // RL16 dead time: all gates off between phases
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_ph_q <= PH_OFF;
      dead_q    <= 2'h0;
    end else if (ce) begin
      if (phase_q != gate_ph_q && dead_q == 2'h0) begin
        dead_q    <= 2'(`GATE_DEAD_CYC);
        gate_ph_q <= PH_OFF;
      end else if (dead_q > 2'h1) begin
        dead_q <= dead_q - 2'h1;
      end else if (dead_q == 2'h1) begin
        dead_q    <= 2'h0;
        gate_ph_q <= phase_q;
      end
    end
  end

  // RL1 forward map, RL2 reverse map
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      high_side_gate_a <= 1'b0;
      high_side_gate_b <= 1'b0;
      low_side_gate_a  <= 1'b0;
      low_side_gate_b  <= 1'b0;
    end else if (ce) begin
      high_side_gate_a <= 1'b0;
      high_side_gate_b <= 1'b0;
      low_side_gate_a  <= 1'b0;
      low_side_gate_b  <= 1'b0;
      if (!overcurrent_shutdown && phase_q == gate_ph_q) begin
        unique case (gate_ph_q)
          PH_CHARGE: begin
            high_side_gate_a <= ~dir_s;
            low_side_gate_b  <= ~dir_s;
            high_side_gate_b <= dir_s;
            low_side_gate_a  <= dir_s;
          end
          PH_SLOW: begin
            low_side_gate_a <= 1'b1;
            low_side_gate_b <= 1'b1;
          end
          PH_FAST: begin
            high_side_gate_b <= ~dir_s;
            low_side_gate_a  <= ~dir_s;
            high_side_gate_a <= dir_s;
            low_side_gate_b  <= dir_s;
          end
          PH_OFF: begin
          end
        endcase
      end
    end
  end

  // RL16 no shoot-through on either half-bridge
  a_no_shoot: assert property (@(posedge clk) disable iff (!rst_n)
    !(high_side_gate_a && low_side_gate_a) &&
    !(high_side_gate_b && low_side_gate_b))
    else $error("shoot-through on a half-bridge");

  // RL12 shutdown latch keeps gates off
  a_sd_gates_off: assert property (@(posedge clk) disable iff (!rst_n)
    ce && overcurrent_shutdown |=> !high_side_gate_a && !high_side_gate_b &&
                             !low_side_gate_a && !low_side_gate_b)
    else $error("gate on during shutdown");

  // RL12 shutdown only leaves on standby
  a_sd_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    ce && overcurrent_shutdown && !stby_s |=> overcurrent_shutdown)
    else $error("shutdown released without standby");

  // RL6 no shutdown before dead band counted
  a_oc_dead: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(overcurrent_shutdown) |-> $past(oc_cnt) ==
      4'(`OC_DEAD_BAND_OSC))
    else $error("shutdown before dead band");

  // RL4 slow decay only follows charge
  a_order_slow: assert property (@(posedge clk) disable iff (!rst_n)
    phase_q == PH_SLOW && $past(phase_q) != PH_SLOW |->
      $past(phase_q) == PH_CHARGE)
    else $error("slow not entered from charge");

  // RL4 charge only follows fast or off
  a_order_chg: assert property (@(posedge clk) disable iff (!rst_n)
    phase_q == PH_CHARGE && $past(phase_q) != PH_CHARGE |->
      $past(phase_q) inside {PH_FAST, PH_OFF})
    else $error("charge entered from wrong phase");

  // RL1 forward charge gate pattern
  a_fwd_charge: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !overcurrent_shutdown && phase_q == PH_CHARGE &&
    gate_ph_q == PH_CHARGE && !dir_s |=>
      high_side_gate_a && low_side_gate_b && !high_side_gate_b)
    else $error("forward charge pattern wrong");

  // RL2 reverse fast gate pattern
  a_rev_fast: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !overcurrent_shutdown && phase_q == PH_FAST &&
    gate_ph_q == PH_FAST && dir_s |=>
      high_side_gate_a && low_side_gate_b && !low_side_gate_a)
    else $error("reverse fast pattern wrong");

  // RL11 no limit hit during fixed blank
  a_ablank: assert property (@(posedge clk) disable iff (!rst_n)
    ce && ablank_q != 10'h000 |=> !limit_hit_q)
    else $error("limit taken in blank");
endmodule

// ---- verification/bridge_model.sv ----
// Purpose: H-bridge coil and sense comparator model for the chopper block
// Assumes: coil current rises one unit per clk on the driving diagonal, falls two on the opposite one
// Notes:   Comparators are always driven; shoot-through reads as over-current
`timescale 1ns/10ps
module bridge_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Gates from the block
  input  wire logic       hs_a,
  input  wire logic       hs_b,
  input  wire logic       ls_a,
  input  wire logic       ls_b,
  // Bench controls
  input  wire logic       force_limit,
  input  wire logic       force_oc,
  input  wire logic [7:0] set_level,
  // Comparator outputs
  output logic            limit,
  output logic            oc
);
  int   mag_q;
  logic neg_q;
  wire logic pos_on = hs_a & ls_b;
  wire logic neg_on = hs_b & ls_a;
  wire logic slow_on = ls_a & ls_b & ~hs_a & ~hs_b;

  // Same diagonal charges, opposite diagonal drains twice as fast
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mag_q <= 0;
      neg_q <= 1'b0;
    end else if (pos_on ^ neg_on) begin
      if (mag_q == 0 || neg_q == neg_on) begin
        mag_q <= mag_q + 1;
        neg_q <= neg_on;
      end else begin
        mag_q <= (mag_q > 2) ? mag_q - 2 : 0;
      end
    end else if (slow_on && mag_q > 0) begin
      mag_q <= mag_q - 1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      limit <= 1'b0;
      oc    <= 1'b0;
    end else begin
      limit <= force_limit | (mag_q >= int'(set_level));
      oc    <= force_oc | (hs_a & ls_a) | (hs_b & ls_b);
    end
  end
endmodule

// ---- verification/tb.sv ----
// Purpose: Self-checking bench for the chopper current control block
// Assumes: oscillator made from clk, period set by osc_half
// Notes:   Phase history is gathered by a monitor on the falling edge
`timescale 1ns/10ps
module tb;
  import chopper_pkg::*;
  logic       clk = 1'b0, rst_n = 1'b0, standby = 1'b0, dc_mode = 1'b0;
  logic       direction = 1'b0, osc = 1'b0, f_lim = 1'b0, f_oc = 1'b0;
  logic [1:0] blank_sel = 2'h0;
  logic [7:0] set_lv = 8'h40;
  logic       limit, oc, hs_a, hs_b, ls_a, ls_b, shut, last_sh = 1'b0;
  logic [1:0] last_pin = 2'h0;
  phase_t     phase_q, last_ph = PH_OFF;
  int failures = 0, checks_done = 0, cyc = 0, osc_half = 80, osc_cnt = 0;
  int ch_start = 0, ch_len = 0, fr_start = 0, fr_len = 0;
  int n_slow = 0, n_fast = 0, ph_age = 0, pin_age = 0;

  chopper_current_control u_chopper_current_control (
    .clk(clk), .ce(1'b1), .rst_n(rst_n), .standby(standby),
    .dc_mode(dc_mode), .blank_sel(blank_sel), .direction(direction),
    .pwm_in(1'b1), .chop_oscillator_clock(osc),
    .current_limit_reached(limit), .overcurrent_in(oc),
    .high_side_gate_a(hs_a), .high_side_gate_b(hs_b),
    .low_side_gate_a(ls_a), .low_side_gate_b(ls_b),
    .overcurrent_shutdown(shut), .phase_q(phase_q));

  bridge_model u_bridge_model (
    .clk(clk), .rst_n(rst_n), .hs_a(hs_a), .hs_b(hs_b), .ls_a(ls_a),
    .ls_b(ls_b), .force_limit(f_lim), .force_oc(f_oc),
    .set_level(set_lv), .limit(limit), .oc(oc));

  always #2 clk = ~clk;

  function automatic logic [3:0] gates_for(phase_t p, logic rev, logic off);
    if (off || p == PH_OFF) return 4'h0;
    if (p == PH_SLOW) return 4'h3;
    return ((p == PH_CHARGE) ^ rev) ? 4'h9 : 4'h6;
  endfunction

  function automatic logic legal(phase_t a, phase_t b);
    return b == PH_OFF || (a == PH_OFF && b == PH_CHARGE) ||
           (a == PH_CHARGE) || (a == PH_SLOW && b == PH_FAST) ||
           (a == PH_FAST && b == PH_CHARGE);
  endfunction

  task automatic check(logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  // Reports the low bound as expected when out of range
  task automatic in_range(int v, int lo, int hi);
    check(32'(v), (v >= lo && v <= hi) ? 32'(v) : 32'(lo));
  endtask

  task automatic conclude();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wait_p(int n);
    repeat (n * 2 * osc_half) @(posedge clk);
  endtask

  task automatic do_reset(logic [1:0] sel, logic dc);
    rst_n     <= 1'b0;
    blank_sel <= sel;
    dc_mode   <= dc;
    f_lim     <= 1'b0;
    repeat (3) @(posedge clk);
    check({hs_a, hs_b, ls_a, ls_b, shut, phase_q}, 7'h03);
    rst_n <= 1'b1;
  endtask

  // Oscillator and run limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (osc_cnt >= osc_half - 1) begin
      osc_cnt <= 0;
      osc     <= ~osc;
    end else begin
      osc_cnt <= osc_cnt + 1;
    end
    if (cyc > 95000) begin
      failures++;
      conclude();
    end
  end

  always @(negedge clk) begin
    ph_age  = (phase_q != last_ph || shut != last_sh) ? 0 : ph_age + 1;
    pin_age = ({direction, standby} != last_pin) ? 0 : pin_age + 1;
    if (rst_n === 1'b1) begin
      check({hs_a & ls_a, hs_b & ls_b}, 2'h0);
      if (ph_age > 4 && pin_age > 8)
        check({hs_a, hs_b, ls_a, ls_b},
              gates_for(phase_q, direction, shut | standby));
      if (phase_q != last_ph) begin
        check(legal(last_ph, phase_q), 1'b1);
        if (last_ph == PH_CHARGE) ch_len = cyc - ch_start;
        if (phase_q == PH_CHARGE) ch_start = cyc;
        if (phase_q == PH_SLOW) n_slow++;
        if (phase_q == PH_FAST) n_fast++;
        if (phase_q == PH_CHARGE && last_ph == PH_FAST) begin
          fr_len   = cyc - fr_start;
          fr_start = cyc;
        end
      end
    end
    last_ph  = phase_q;
    last_sh  = shut;
    last_pin = {direction, standby};
  end

  initial begin
    int h, s0, f0, n;
    void'($urandom(32'h1736));
    do_reset(2'h0, 1'b0);
    repeat (2) begin
      h = $urandom_range(100, 70);
      s0 = n_slow;
      f0 = n_fast;
      osc_half  <= h;
      direction <= 1'($urandom_range(1, 0));
      set_lv    <= 8'($urandom_range(200, 40));
      repeat (48 * 2 * h) @(posedge clk);
      check(32'(fr_len), 32'(32 * h));
      check(n_slow > s0 && n_fast > f0, 1'b1);
      $display("test frame half %0d done", h);
    end
    osc_half <= 80;
    do_reset(2'h3, 1'b0);
    f_lim <= 1'b1;
    wait_p(34);
    in_range(ch_len, 138, 150);
    $display("test stepping blank done");
    for (int c = 0; c < 4; c++) begin
      do_reset(2'(c), 1'b1);
      f_lim <= 1'b1;
      wait_p(34);
      n = (c < 2) ? 4 : 2 * c + 2;
      in_range(ch_len, n * 160 - 2, n * 160 + 10);
      $display("test dc blank code %0d done", c);
    end
    do_reset(2'h0, 1'b0);
    wait_p(20);
    f_oc <= 1'b1;
    wait_p(2);
    f_oc <= 1'b0;
    wait_p(1);
    check(shut, 1'b0);
    f_oc <= 1'b1;
    n = 0;
    while (shut !== 1'b1 && n < 12 * 160) begin
      @(posedge clk);
      n++;
    end
    in_range(n, 4 * 160, 8 * 160 + 10);
    f_oc <= 1'b0;
    wait_p(3);
    check({shut, hs_a, hs_b, ls_a, ls_b}, 5'h10);
    standby <= 1'b1;
    wait_p(1);
    check(shut, 1'b0);
    standby <= 1'b0;
    wait_p(20);
    check(phase_q != PH_OFF, 1'b1);
    $display("test over-current done");
    conclude();
  end
endmodule
